// [verilog/lrs_cfg.svh]
// lrs_cfg.svh: offsets, field positions, reset values and counts for the lane status block
// assumes inclusion by its bare name from the lane and top design files of the block
`ifndef LRS_CFG_SVH
`define LRS_CFG_SVH

`define LRS_LANES 4
`define LRS_ADDR_CTRL 12'h000
`define LRS_ADDR_LANE_EN 12'h004
`define LRS_ADDR_STATUS 12'h008
`define LRS_ADDR_STATE 12'h00c
`define LRS_CTRL_PIPE 0
`define LRS_CTRL_FABRST 1
`define LRS_CTRL_SHARED 2
`define LRS_CTRL_RST 3'h0
`define LRS_LANE_EN_RST 4'hf
`define LRS_STAT_READY 0
`define LRS_STAT_VALID 4
`define LRS_STAT_IDLE 8
`define LRS_STAT_STABLE 12
`define LRS_VALID_DLY 3'h4
`define LRS_TX_DIV 2'h3
`define LRS_RX_DIV 2'h2

`endif

// [verilog/lrs_pkg.sv]
// lrs_pkg.sv: types shared by the lane status block
// assumes nothing beyond a SystemVerilog compiler
package lrs_pkg;

	typedef enum logic [1:0] {
		lrs_hold = 2'b00,
		lrs_settle = 2'b01,
		lrs_live = 2'b10
	} lrs_state_t;

	typedef logic [3:0] lrs_lanes_t;

endpackage

// [verilog/lrs_lane.sv]
// lrs_lane.sv: ready, data-valid, idle and clock-stable flags of one lane
// assumes lane inputs synchronous to pclk and rx_tick marking recovered clock edges
`timescale 1ns/1ps
`include "lrs_cfg.svh"

module lrs_lane (
	input wire logic pclk, // block clock
	input wire logic presetn, // async reset, active low
	input wire logic pcs_arst_n, // pcs async reset, active low
	input wire logic pipe_mode, // pipe receive mode
	input wire logic rx_tick, // recovered clock edge
	input wire logic cdr_lock, // cdr phase locked
	input wire logic deser_pwr, // deserializer powered up
	input wire logic sig_present, // serial transitions arriving
	input wire logic align_done, // initial comma alignment done
	input wire logic tx_pll_lock, // transmit pll locked
	input wire logic idle_detect, // raw electrical idle detect
	output logic ready_r, // receive ready flag
	output logic valid_r, // receive data-valid flag
	output logic idle_r, // electrical idle flag
	output logic stable_r, // transmit clock stable flag
	output lrs_pkg::lrs_state_t state_r // receive sequencer state
);
	import lrs_pkg::*;

	logic [2:0] cnt_r;

	// R6 ready from lock
	// R7 low without data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= cdr_lock & deser_pwr & sig_present;
		end
	end

	// R10 pll lock flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_r <= 1'b0;
		end else begin
			stable_r <= tx_pll_lock;
		end
	end

	// R9 set now, clear on tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_r <= 1'b0;
		end else if (idle_detect) begin
			idle_r <= 1'b1;
		end else if (rx_tick) begin
			idle_r <= 1'b0;
		end
	end

	// R2 self-reset without lock
	always_ff @(posedge pclk or negedge pcs_arst_n) begin
		if (!pcs_arst_n) begin
			state_r <= lrs_hold;
			cnt_r <= 3'h0;
			valid_r <= 1'b0;
		end else if (!ready_r) begin
			state_r <= lrs_hold;
			cnt_r <= 3'h0;
			valid_r <= 1'b0;
		end else begin
			case (state_r)
				lrs_hold: begin
					// R5 pipe waits alignment
					if (!pipe_mode || align_done) begin
						state_r <= lrs_settle;
						cnt_r <= `LRS_VALID_DLY - 3'h1;
					end
				end
				lrs_settle: begin
					// R3 valid shortly after
					if (cnt_r == 3'h0) begin
						state_r <= lrs_live;
						// R1 data now real
						valid_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				lrs_live: begin
					valid_r <= 1'b1;
				end
				default: begin
					state_r <= lrs_hold;
					valid_r <= 1'b0;
				end
			endcase
		end
	end

	sequence s_ready_rise;
		$rose(ready_r) && !pipe_mode;
	endsequence

	sequence s_ready_held;
		(ready_r && !pipe_mode)[*4];
	endsequence

	a_ready_lock: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(cdr_lock && deser_pwr && sig_present) |=> ready_r)
		else $error("ready did not follow cdr lock");
	a_ready_no_data: assert property (@(posedge pclk) disable iff (!presetn) // R7
		!sig_present |=> !ready_r)
		else $error("ready high without serial data");
	a_valid_after_ready: assert property (@(posedge pclk) disable iff (!pcs_arst_n) // R3
		s_ready_rise ##1 s_ready_held |-> !valid_r ##1 valid_r)
		else $error("valid not five cycles after ready");
	a_valid_needs_ready: assert property (@(posedge pclk) disable iff (!pcs_arst_n) // R1
		!ready_r |=> !valid_r)
		else $error("valid high while ready low");
	a_pipe_align_wait: assert property (@(posedge pclk) disable iff (!pcs_arst_n) // R5
		(state_r == lrs_hold && pipe_mode && !align_done) |=> state_r == lrs_hold && !valid_r)
		else $error("pipe valid before alignment");
	a_idle_set_now: assert property (@(posedge pclk) disable iff (!presetn) // R9
		idle_detect |=> idle_r)
		else $error("idle flag late");
	a_idle_clear_tick: assert property (@(posedge pclk) disable iff (!presetn) // R9
		$fell(idle_r) |-> $past(rx_tick) && !$past(idle_detect))
		else $error("idle cleared off the recovered edge");
	a_tx_stable_drop: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(tx_pll_lock ##1 !tx_pll_lock) |=> !stable_r && $past(stable_r))
		else $error("clock stable flag wrong");

endmodule

// [verilog/lrs_top.sv]
// lrs_top.sv: four-lane status flags, fifo clock enables and their APB register file
// assumes lane status inputs synchronous to pclk; fifo and lane clocks are enable pulses
//
// Added by the designer: the register addresses and the APB interface to the registers.

`timescale 1ns/1ps
`include "lrs_cfg.svh"

// Overview of operation
// R1 - data-valid high only when datapath initialised
// R2 - non-pipe receive pcs self-resets without lock
// R3 - data-valid rises shortly after ready rises
// R4 - fabric may hold pcs reset until ready
// R5 - pipe valid needs lock and comma alignment
// R6 - ready when cdr locked and deserializer up
// R7 - ready low without incoming serial data
// R8 - loopback: fabric releases transmitter before waiting
// R9 - idle sets at once, clears on edge
// R10 - clock-stable high while transmit pll locked
// R11 - lane zero clock shared by all lanes
// R12 - shared mode drives every fifo clock
// R13 - lane index runs zero to three only
// R14 - pcs reset is async active-low fabric input
// R15 - fabric synchronises ready and stable flags
module lrs_top (
	input wire logic pclk, // 40 MHz block clock
	input wire logic presetn, // async reset, active low
	input wire logic [11:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire lrs_pkg::lrs_lanes_t cdr_lock, // cdr locked per lane
	input wire lrs_pkg::lrs_lanes_t deser_pwr, // deserializer powered per lane
	input wire lrs_pkg::lrs_lanes_t sig_present, // serial transitions per lane
	input wire lrs_pkg::lrs_lanes_t align_done, // comma alignment done per lane
	input wire lrs_pkg::lrs_lanes_t tx_pll_lock, // transmit pll lock per lane
	input wire lrs_pkg::lrs_lanes_t idle_detect, // raw idle detect per lane
	input wire lrs_pkg::lrs_lanes_t pcs_async_reset_n, // pcs reset per lane, low
	output lrs_pkg::lrs_lanes_t rx_ready, // receive ready per lane
	output lrs_pkg::lrs_lanes_t rx_data_valid_flag, // data valid per lane
	output lrs_pkg::lrs_lanes_t rx_idle, // electrical idle per lane
	output lrs_pkg::lrs_lanes_t tx_clk_stable, // transmit clock stable per lane
	output lrs_pkg::lrs_lanes_t rx_fifo_clock, // receive fifo clock enable
	output lrs_pkg::lrs_lanes_t tx_fifo_clock, // transmit fifo clock enable
	output logic shared_lane_clock // lane zero transmit clock enable
);
	import lrs_pkg::*;

	logic [2:0] ctrl_r;
	lrs_lanes_t lane_en_r;
	lrs_lanes_t lane_arst_n;
	lrs_state_t lane_state [`LRS_LANES];
	logic [1:0] tx_div_r;
	logic [1:0] rx_div_r;
	logic tx_tick_r;
	logic rx_tick_r;
	logic apb_setup;
	logic apb_write;
	logic addr_hit;
	logic [31:0] rd_data;

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite;

	// transmit clock divider, one pulse every four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_div_r <= 2'h0;
			tx_tick_r <= 1'b0;
		end else begin
			if (tx_div_r == `LRS_TX_DIV) begin
				tx_div_r <= 2'h0;
			end else begin
				tx_div_r <= tx_div_r + 2'h1;
			end
			tx_tick_r <= (tx_div_r == `LRS_TX_DIV);
		end
	end

	// recovered clock divider, one pulse every three cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_div_r <= 2'h0;
			rx_tick_r <= 1'b0;
		end else begin
			if (rx_div_r == `LRS_RX_DIV) begin
				rx_div_r <= 2'h0;
			end else begin
				rx_div_r <= rx_div_r + 2'h1;
			end
			rx_tick_r <= (rx_div_r == `LRS_RX_DIV);
		end
	end

	// R13 four lanes only
	genvar g;
	generate
		for (g = 0; g < `LRS_LANES; g++) begin : gen_lane
			// R14 async pcs reset
			// R4 fabric holds reset
			assign lane_arst_n[g] = presetn & lane_en_r[g]
				& (pcs_async_reset_n[g] | ~ctrl_r[`LRS_CTRL_FABRST]);

			lrs_lane u_lane (
				.pclk(pclk),
				.presetn(presetn),
				.pcs_arst_n(lane_arst_n[g]),
				.pipe_mode(ctrl_r[`LRS_CTRL_PIPE]),
				.rx_tick(rx_tick_r),
				.cdr_lock(cdr_lock[g]),
				.deser_pwr(deser_pwr[g]),
				.sig_present(sig_present[g]),
				.align_done(align_done[g]),
				.tx_pll_lock(tx_pll_lock[g]),
				.idle_detect(idle_detect[g]),
				.ready_r(rx_ready[g]),
				.valid_r(rx_data_valid_flag[g]),
				.idle_r(rx_idle[g]),
				.stable_r(tx_clk_stable[g]),
				.state_r(lane_state[g])
			);

			a_fabric_reset_hold: assert property (@(posedge pclk) disable iff (!presetn) // R4
				(ctrl_r[`LRS_CTRL_FABRST] && !pcs_async_reset_n[g])
				|-> ##1 !rx_data_valid_flag[g])
				else $error("valid high while fabric holds pcs reset");

			sequence s_pcs_release;
				$rose(lane_arst_n[g]) && rx_ready[g] && (!ctrl_r[`LRS_CTRL_PIPE] || align_done[g]);
			endsequence

			sequence s_pcs_kept;
				(rx_ready[g] && lane_arst_n[g]) [*4];
			endsequence

			a_release_valid: assert property (@(posedge pclk) disable iff (!presetn) // R4
				s_pcs_release ##1 s_pcs_kept |=> rx_data_valid_flag[g] || !lane_arst_n[g])
				else $error("valid late after pcs release");
		end
	endgenerate

	// R11 lane zero clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_lane_clock <= 1'b0;
		end else begin
			shared_lane_clock <= tx_tick_r & tx_clk_stable[0];
		end
	end

	// R12 fifo clocks from shared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fifo_clock <= 4'h0;
			rx_fifo_clock <= 4'h0;
		end else begin
			for (int i = 0; i < `LRS_LANES; i++) begin
				if (ctrl_r[`LRS_CTRL_SHARED]) begin
					tx_fifo_clock[i] <= tx_tick_r & tx_clk_stable[0];
					rx_fifo_clock[i] <= tx_tick_r & tx_clk_stable[0];
				end else begin
					tx_fifo_clock[i] <= tx_tick_r & tx_clk_stable[i];
					rx_fifo_clock[i] <= rx_tick_r & rx_ready[i];
				end
			end
		end
	end

	// control register: pipe mode, fabric reset control, shared clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `LRS_CTRL_RST;
		end else if (apb_write && paddr == `LRS_ADDR_CTRL) begin
			ctrl_r <= pwdata[2:0];
		end
	end

	// lane enable mask, a cleared bit holds that lane's pcs in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_en_r <= `LRS_LANE_EN_RST;
		end else if (apb_write && paddr == `LRS_ADDR_LANE_EN) begin
			lane_en_r <= pwdata[3:0];
		end
	end

	// read mux and address decode
	always_comb begin
		rd_data = 32'h0;
		addr_hit = 1'b1;
		if (paddr == `LRS_ADDR_CTRL) begin
			rd_data[2:0] = ctrl_r;
		end else if (paddr == `LRS_ADDR_LANE_EN) begin
			rd_data[3:0] = lane_en_r;
		end else if (paddr == `LRS_ADDR_STATUS) begin
			rd_data[`LRS_STAT_READY +: 4] = rx_ready;
			rd_data[`LRS_STAT_VALID +: 4] = rx_data_valid_flag;
			rd_data[`LRS_STAT_IDLE +: 4] = rx_idle;
			rd_data[`LRS_STAT_STABLE +: 4] = tx_clk_stable;
		end else if (paddr == `LRS_ADDR_STATE) begin
			for (int i = 0; i < `LRS_LANES; i++) begin
				rd_data[2 * i +: 2] = lane_state[i];
			end
		end else begin
			addr_hit = 1'b0;
		end
	end

	// answer in the first access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_hit;
			if (apb_setup && !pwrite) begin
				prdata <= rd_data;
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	sequence s_apb_setup;
		psel && !penable;
	endsequence

	sequence s_apb_access;
		psel && penable && pready;
	endsequence

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		s_apb_setup |=> pready;
	endproperty

	property p_apb_one_beat;
		@(posedge pclk) disable iff (!presetn)
		s_apb_access ##1 !apb_setup |-> !pready;
	endproperty

	property p_rx_tick_gap;
		@(posedge pclk) disable iff (!presetn)
		rx_tick_r |=> !rx_tick_r [*2] ##1 rx_tick_r;
	endproperty

	property p_lane_off_quiet;
		@(posedge pclk) disable iff (!presetn)
		(rx_data_valid_flag & ~lane_en_r) == 4'h0;
	endproperty

	property p_lane_en_write;
		@(posedge pclk) disable iff (!presetn)
		(apb_write && paddr == `LRS_ADDR_LANE_EN) |=> lane_en_r == $past(pwdata[3:0]);
	endproperty

	property p_status_read_only;
		@(posedge pclk) disable iff (!presetn)
		(apb_write && (paddr == `LRS_ADDR_STATUS || paddr == `LRS_ADDR_STATE))
		|=> ctrl_r == $past(ctrl_r) && lane_en_r == $past(lane_en_r);
	endproperty

	property p_bus_quiet;
		@(posedge pclk) disable iff (!presetn)
		!apb_setup |=> !pready && !pslverr && prdata == 32'h0;
	endproperty

	property p_mapped_no_error;
		@(posedge pclk) disable iff (!presetn)
		(apb_setup && addr_hit) |=> !pslverr;
	endproperty

	property p_status_read;
		@(posedge pclk) disable iff (!presetn)
		(apb_setup && !pwrite && paddr == `LRS_ADDR_STATUS)
		|=> prdata[`LRS_STAT_READY +: 4] == $past(rx_ready)
		&& prdata[`LRS_STAT_VALID +: 4] == $past(rx_data_valid_flag);
	endproperty

	property p_rx_fifo_idle;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[`LRS_CTRL_SHARED] && !rx_tick_r) |=> rx_fifo_clock == 4'h0;
	endproperty

	property p_tx_fifo_idle;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[`LRS_CTRL_SHARED] && !tx_tick_r) |=> tx_fifo_clock == 4'h0;
	endproperty

	property p_shared_needs_stable;
		@(posedge pclk) disable iff (!presetn)
		!tx_clk_stable[0] |=> !shared_lane_clock;
	endproperty

	property p_shared_spacing;
		@(posedge pclk) disable iff (!presetn)
		shared_lane_clock |=> !shared_lane_clock [*3];
	endproperty

	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not in first access cycle");
	a_apb_one_beat: assert property (p_apb_one_beat)
		else $error("pready held past the access cycle");
	a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_setup && !addr_hit) |=> pslverr && pready)
		else $error("unmapped address without error");
	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_write && paddr == `LRS_ADDR_CTRL) |=> ctrl_r == $past(pwdata[2:0]))
		else $error("control write lost");
	a_lane_range: assert property (@(posedge pclk) disable iff (!presetn) // R13
		(apb_setup && !pwrite && paddr == `LRS_ADDR_LANE_EN) |=> prdata[31:4] == 28'h0)
		else $error("lane mask wider than four lanes");
	a_shared_clock: assert property (@(posedge pclk) disable iff (!presetn) // R11
		shared_lane_clock |-> $past(tx_tick_r) && $past(tx_clk_stable[0]))
		else $error("shared clock not from lane zero");
	a_fifo_shared: assert property (@(posedge pclk) disable iff (!presetn) // R12
		$past(ctrl_r[`LRS_CTRL_SHARED])
		|-> tx_fifo_clock == {4{shared_lane_clock}} && rx_fifo_clock == {4{shared_lane_clock}})
		else $error("fifo clocks not from shared clock");
	a_tx_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
		tx_tick_r |=> !tx_tick_r [*3] ##1 tx_tick_r)
		else $error("transmit clock divider period wrong");
	a_rx_fifo_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[`LRS_CTRL_SHARED] && !rx_ready[1]) |=> !rx_fifo_clock[1])
		else $error("receive fifo clock without ready");
	a_rx_tick_gap: assert property (p_rx_tick_gap)
		else $error("recovered clock divider period wrong");
	a_lane_off_quiet: assert property (p_lane_off_quiet) // R14
		else $error("valid high on a disabled lane");
	a_lane_en_write: assert property (p_lane_en_write)
		else $error("lane enable write lost");
	a_status_read_only: assert property (p_status_read_only)
		else $error("write to a read-only register took effect");
	a_bus_quiet: assert property (p_bus_quiet)
		else $error("apb answer outside an access cycle");
	a_mapped_no_error: assert property (p_mapped_no_error)
		else $error("error on a mapped address");
	a_status_read: assert property (p_status_read) // R1
		else $error("status read does not match the flags");
	a_rx_fifo_idle: assert property (p_rx_fifo_idle)
		else $error("receive fifo clock off the recovered tick");
	a_tx_fifo_idle: assert property (p_tx_fifo_idle)
		else $error("transmit fifo clock off the divider tick");
	a_shared_needs_stable: assert property (p_shared_needs_stable) // R11
		else $error("shared clock without lane zero stable");
	a_shared_spacing: assert property (p_shared_spacing) // R11
		else $error("shared clock pulses too close");

endmodule

// [dv/lrs_fabric_model.sv]
// lrs_fabric_model.sv: fabric-side logic that owns the lane pcs resets
// assumes ready and stable flags arrive without a known phase to pclk
`timescale 1ns/1ps

module lrs_fabric_model (
	input wire logic pclk, // fabric clock
	input wire logic presetn, // reset, active low
	input wire logic slow, // one more stage before pcs release
	input wire lrs_pkg::lrs_lanes_t rx_ready, // ready flags from the lanes
	input wire lrs_pkg::lrs_lanes_t tx_clk_stable, // stable flags from the lanes
	output lrs_pkg::lrs_lanes_t pcs_async_reset_n, // pcs reset per lane, low
	output lrs_pkg::lrs_lanes_t stable_sync, // stable flags in fabric domain
	output logic tx_rst_n // transmitter reset, active low
);
	import lrs_pkg::*;
	lrs_lanes_t rdy_s1_r, rdy_s2_r, rdy_s3_r, stb_s1_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_s1_r <= '0;
			rdy_s2_r <= '0;
			rdy_s3_r <= '0;
			stb_s1_r <= '0;
			stable_sync <= '0;
		end else begin
			rdy_s1_r <= rx_ready;
			rdy_s2_r <= rdy_s1_r;
			rdy_s3_r <= rdy_s2_r;
			stb_s1_r <= tx_clk_stable;
			stable_sync <= stb_s1_r;
		end
	end

	assign pcs_async_reset_n = slow ? rdy_s3_r : rdy_s2_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_rst_n <= 1'b0;
		end else begin
			tx_rst_n <= 1'b1;
		end
	end
endmodule

// [dv/testbench.sv]
// testbench.sv: self-checking bench for the four-lane status block
// assumes lrs_pkg, lrs_top and lrs_fabric_model compiled before it
`timescale 1ns/1ps
`include "lrs_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("FAIL t=%0t got %h exp %h", $time, g, e); end end

module testbench;
	import lrs_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic [11:0] paddr = '0;
	logic psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, shared_lane_clock, err, tx_rst_n;
	lrs_lanes_t cdr_lock = '0, deser_pwr = '0, sig_present = '0, align_done = '0;
	lrs_lanes_t tx_pll_lock = '0, idle_detect = '0;
	lrs_lanes_t pcs_async_reset_n, rx_ready, rx_data_valid_flag, rx_idle, tx_clk_stable;
	lrs_lanes_t rx_fifo_clock, tx_fifo_clock, stable_sync;
	int bad_count = 0, check_count = 0;

	always #12.5 pclk = ~pclk;

	lrs_top lrs_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .cdr_lock, .deser_pwr, .sig_present, .align_done,
		.tx_pll_lock, .idle_detect, .pcs_async_reset_n, .rx_ready, .rx_data_valid_flag,
		.rx_idle, .tx_clk_stable, .rx_fifo_clock, .tx_fifo_clock, .shared_lane_clock);

	lrs_fabric_model lrs_fabric_model_inst (.pclk, .presetn, .slow, .rx_ready,
		.tx_clk_stable, .pcs_async_reset_n, .stable_sync, .tx_rst_n);

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// one apb transfer; read data and error land in rd and err
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_valid(input lrs_lanes_t v);
		repeat (20) if (rx_data_valid_flag !== v) tick(1);
	endtask

	task automatic t_regs();
		apb(`LRS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		apb(`LRS_ADDR_LANE_EN, 1'b0, 32'h0);
		`CHK(rd, 32'hf)
		apb(12'h010, 1'b1, 32'h7);
		`CHK(err, 1'b1)
		apb(`LRS_ADDR_STATUS, 1'b1, 32'hffffffff);
		`CHK(err, 1'b0)
		apb(`LRS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK({err, rd}, 33'h0)
		$display("test regs done");
	endtask

	task automatic t_stable();
		@(posedge pclk);
		tx_pll_lock <= 4'hd;
		tick(1);
		`CHK(tx_clk_stable, 4'hd)
		@(posedge pclk);
		tx_pll_lock <= 4'hf;
		tick(1);
		`CHK(tx_clk_stable, 4'hf)
		@(posedge pclk);
		tx_pll_lock <= 4'h6;
		tick(1);
		`CHK(tx_clk_stable, 4'h6)
		@(posedge pclk);
		tx_pll_lock <= 4'hf;
		tick(3);
		`CHK({tx_clk_stable, stable_sync}, 8'hff)
		$display("test stable done");
	endtask

	task automatic t_ready();
		`CHK(tx_rst_n, 1'b1)
		apb(`LRS_ADDR_LANE_EN, 1'b1, 32'h1);
		@(posedge pclk);
		cdr_lock <= 4'hf;
		deser_pwr <= 4'hf;
		sig_present <= 4'hf;
		tick(1);
		`CHK(rx_ready, 4'hf)
		tick(4);
		`CHK(rx_data_valid_flag, 4'h0)
		tick(1);
		`CHK(rx_data_valid_flag, 4'h1)
		apb(`LRS_ADDR_STATUS, 1'b0, 32'h0);
		`CHK(rd, 32'h0000f01f)
		apb(`LRS_ADDR_STATE, 1'b0, 32'h0);
		`CHK(rd, 32'h2)
		@(posedge pclk);
		sig_present <= 4'he;
		tick(1);
		`CHK(rx_ready, 4'he)
		tick(1);
		`CHK(rx_data_valid_flag, 4'h0)
		apb(`LRS_ADDR_LANE_EN, 1'b1, 32'hf);
		@(posedge pclk);
		sig_present <= 4'hf;
		$display("test ready done");
	endtask

	task automatic t_pipe();
		apb(`LRS_ADDR_CTRL, 1'b1, 32'h1);
		@(posedge pclk);
		cdr_lock <= 4'h0;
		tick(3);
		`CHK(rx_data_valid_flag, 4'h0)
		@(posedge pclk);
		cdr_lock <= 4'hf;
		tick(10);
		`CHK(rx_data_valid_flag, 4'h0)
		@(posedge pclk);
		align_done <= 4'hf;
		wait_valid(4'hf);
		`CHK(rx_data_valid_flag, 4'hf)
		$display("test pipe done");
	endtask

	task automatic t_fabric();
		int n;
		apb(`LRS_ADDR_CTRL, 1'b1, 32'h2);
		@(posedge pclk);
		cdr_lock <= 4'h0;
		slow <= 1'b1;
		tick(4);
		`CHK(rx_data_valid_flag, 4'h0)
		@(posedge pclk);
		cdr_lock <= 4'hf;
		for (n = 0; n < 20 && pcs_async_reset_n !== 4'hf; n++) begin
			tick(1);
			`CHK(rx_data_valid_flag & ~pcs_async_reset_n, 4'h0)
		end
		wait_valid(4'hf);
		`CHK(rx_data_valid_flag, 4'hf)
		$display("test fabric done");
	endtask

	task automatic t_idle();
		int n;
		@(posedge pclk);
		idle_detect <= 4'h2;
		tick(1);
		`CHK(rx_idle, 4'h2)
		@(posedge pclk);
		idle_detect <= 4'h0;
		for (n = 0; n < 3 && rx_idle !== 4'h0; n++) tick(1);
		`CHK(rx_idle, 4'h0)
		$display("test idle done");
	endtask

	task automatic t_shared();
		int n;
		logic [7:0] k;
		apb(`LRS_ADDR_CTRL, 1'b1, 32'h0);
		k = 8'h0;
		for (n = 0; n < 12; n++) begin
			tick(1);
			k = k + {7'h0, rx_fifo_clock[2]};
		end
		`CHK(k, 8'h4)
		apb(`LRS_ADDR_CTRL, 1'b1, 32'h4);
		tick(1);
		k = 8'h0;
		for (n = 0; n < 12; n++) begin
			tick(1);
			k = k + {7'h0, shared_lane_clock};
			`CHK(rx_fifo_clock, {4{shared_lane_clock}})
			`CHK(tx_fifo_clock, {4{shared_lane_clock}})
		end
		`CHK(k, 8'h3)
		$display("test shared done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (11) @(posedge pclk);
		#1 `CHK({rx_ready, rx_data_valid_flag, tx_clk_stable, pready}, 13'h0)
		@(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_stable();
		t_ready();
		t_pipe();
		t_fabric();
		t_idle();
		t_shared();
		close_out();
	end

	// cuts a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		close_out();
	end
endmodule
